/* shared/dcef_pkg.sv */
// Package with the register map, field layout and carrier types of the event flag block.
package dcef_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CLEAR_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] PENDING_OFS = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions in the status, clear and mask registers
  // ----------------------------------------------------------------
  localparam int CH6_ANY_BIT = 24;
  localparam int CH6_DONE_BIT = 25;
  localparam int CH6_HALF_BIT = 26;
  localparam int CH6_FAULT_BIT = 27;
  localparam int CH7_ANY_BIT = 28;
  localparam int CH7_DONE_BIT = 29;
  localparam int CH7_HALF_BIT = 30;

  // Channel groups are four bits apart, starting at the channel 6 group.
  localparam int FIRST_CH_BIT = 24;
  localparam int CH_STRIDE = 4;
  localparam int CH_COUNT = 2;
  localparam int ANY_POS = 0;
  localparam int DONE_POS = 1;
  localparam int HALF_POS = 2;
  localparam int FAULT_POS = 3;

  // Only these bits can ever hold a flag; all others read as zero.
  localparam logic [31:0] FLAG_MASK = 32'h7F00_0000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fault_event;
    logic halfway_event;
    logic completion_event;
  } dcef_evt_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dcef_bus_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] mask;
    logic [31:0] rdata;
  } dcef_state_t;

endpackage

/* logic/dcef_flags.sv */
// Event flag register block for DMA channels 6 and 7 with clear, mask and interrupt.
//
// ------------------------------------------------------------------
// Contract
// ------------------------------------------------------------------
module dcef_flags (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire dcef_pkg::dcef_evt_t ch6_evt_in,
  input wire dcef_pkg::dcef_evt_t ch7_evt_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  output logic [6:0] flags_out
);

  // ----------------------------------------------------------------
  // State and bus capture
  // ----------------------------------------------------------------
  dcef_pkg::dcef_state_t state_reg;
  dcef_pkg::dcef_state_t state_next;
  dcef_pkg::dcef_bus_t bus;
  dcef_pkg::dcef_evt_t evt [dcef_pkg::CH_COUNT];
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] rd_value;

  assign bus.wr = wr_in;
  assign bus.rd = rd_in;
  assign bus.addr = addr_in;
  assign bus.wdata = wdata_in;
  assign evt[0] = ch6_evt_in;
  assign evt[1] = ch7_evt_in;

  // ----------------------------------------------------------------
  // Per-channel event to flag mapping
  // ----------------------------------------------------------------
  // Each channel owns a group of four bits. The channel 7 fault bit would
  // land on bit 31, which is outside the flag field and is masked off, but
  // a channel 7 fault still raises that channel's any-event flag.
  genvar ch;
  generate
    for (ch = 0; ch < dcef_pkg::CH_COUNT; ch++) begin : g_ch
      localparam int BASE = dcef_pkg::FIRST_CH_BIT + ch * dcef_pkg::CH_STRIDE;
      assign set_vec[BASE + dcef_pkg::ANY_POS] = evt[ch].fault_event
        | evt[ch].halfway_event | evt[ch].completion_event;
      assign set_vec[BASE + dcef_pkg::DONE_POS] = evt[ch].completion_event;
      assign set_vec[BASE + dcef_pkg::HALF_POS] = evt[ch].halfway_event;
      assign set_vec[BASE + dcef_pkg::FAULT_POS] = evt[ch].fault_event;
    end
  endgenerate
  assign set_vec[dcef_pkg::FIRST_CH_BIT-1:0] = '0;

  // ----------------------------------------------------------------
  // Clear decode
  // ----------------------------------------------------------------
  // Only the clear register can remove a flag; a write to the status
  // offset decodes to nothing here.
  always_comb begin
    clr_vec = '0;
    if (bus.wr && (bus.addr == dcef_pkg::CLEAR_OFS)) begin
      clr_vec = bus.wdata & dcef_pkg::FLAG_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (bus.addr)
      dcef_pkg::STATUS_OFS: begin
        rd_value = state_reg.flags;
      end
      dcef_pkg::MASK_OFS: begin
        rd_value = state_reg.mask;
      end
      dcef_pkg::PENDING_OFS: begin
        rd_value = state_reg.flags & state_reg.mask;
      end
      default: begin
        // The clear register is write-only and reads as zero, as does
        // every unmapped offset.
        rd_value = dcef_pkg::UNMAPPED_RD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // The set term is applied after the clear so that an event landing
    // in the same cycle as its clear is never lost.
    state_next.flags = ((state_reg.flags & ~clr_vec) | set_vec)
      & dcef_pkg::FLAG_MASK;
    if (bus.wr && (bus.addr == dcef_pkg::MASK_OFS)) begin
      state_next.mask = bus.wdata & dcef_pkg::FLAG_MASK;
    end
    // Read data stand for exactly one cycle and are zero otherwise.
    state_next.rdata = bus.rd ? rd_value : dcef_pkg::RDATA_RST;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg.flags <= dcef_pkg::FLAGS_RST;
      state_reg.mask <= dcef_pkg::MASK_RST;
      state_reg.rdata <= dcef_pkg::RDATA_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_out = state_reg.rdata;
  assign irq_out = |(state_reg.flags & state_reg.mask);
  assign flags_out = state_reg.flags[dcef_pkg::CH7_HALF_BIT:dcef_pkg::CH6_ANY_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic clr_wr;
  logic status_wr;
  assign clr_wr = wr_in && (addr_in == dcef_pkg::CLEAR_OFS);
  assign status_wr = wr_in && (addr_in == dcef_pkg::STATUS_OFS);

  ch6_done_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ch6_evt_in.completion_event |=> state_reg.flags[dcef_pkg::CH6_DONE_BIT]
  ) else $error("Channel 6 done flag missed its completion event.");

  ch6_half_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ch6_evt_in.halfway_event |=> state_reg.flags[dcef_pkg::CH6_HALF_BIT]
  ) else $error("Channel 6 halfway flag missed its event.");

  ch6_fault_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ch6_evt_in.fault_event |=> state_reg.flags[dcef_pkg::CH6_FAULT_BIT]
  ) else $error("Channel 6 fault flag missed its event.");

  ch7_any_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (|ch7_evt_in) |=> state_reg.flags[dcef_pkg::CH7_ANY_BIT]
  ) else $error("Channel 7 any-event flag missed an event.");

  ch7_done_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ch7_evt_in.completion_event |=> state_reg.flags[dcef_pkg::CH7_DONE_BIT]
  ) else $error("Channel 7 done flag missed its completion event.");

  ch7_half_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ch7_evt_in.halfway_event |=> state_reg.flags[dcef_pkg::CH7_HALF_BIT]
  ) else $error("Channel 7 halfway flag missed its event.");

  ch6_any_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (|ch6_evt_in) |=> state_reg.flags[dcef_pkg::CH6_ANY_BIT]
  ) else $error("Channel 6 any-event flag missed an event.");

  ch6_any_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH6_ANY_BIT]) |-> $past(|ch6_evt_in)
  ) else $error("Channel 6 any-event flag rose with no event.");

  ch6_done_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH6_DONE_BIT]) |-> $past(ch6_evt_in.completion_event)
  ) else $error("Channel 6 done flag rose with no completion event.");

  ch6_half_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH6_HALF_BIT]) |-> $past(ch6_evt_in.halfway_event)
  ) else $error("Channel 6 halfway flag rose with no event.");

  ch6_fault_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH6_FAULT_BIT]) |-> $past(ch6_evt_in.fault_event)
  ) else $error("Channel 6 fault flag rose with no event.");

  ch7_any_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH7_ANY_BIT]) |-> $past(|ch7_evt_in)
  ) else $error("Channel 7 any-event flag rose with no event.");

  ch7_done_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH7_DONE_BIT]) |-> $past(ch7_evt_in.completion_event)
  ) else $error("Channel 7 done flag rose with no completion event.");

  ch7_half_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_reg.flags[dcef_pkg::CH7_HALF_BIT]) |-> $past(ch7_evt_in.halfway_event)
  ) else $error("Channel 7 halfway flag rose with no event.");

  // ----------------------------------------------------------------
  // Clear checks
  // ----------------------------------------------------------------

  flag_clear_only_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $fell(state_reg.flags[dcef_pkg::CH6_DONE_BIT])
      |-> $past(clr_wr) && $past(wdata_in[dcef_pkg::CH6_DONE_BIT])
  ) else $error("Channel 6 done flag fell without a clear write.");

  clear_takes_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    clr_wr && wdata_in[dcef_pkg::CH7_DONE_BIT] && !ch7_evt_in.completion_event
      |=> !state_reg.flags[dcef_pkg::CH7_DONE_BIT]
  ) else $error("Channel 7 done flag survived its clear.");

  set_beats_clear_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    clr_wr && wdata_in[dcef_pkg::CH6_FAULT_BIT] && ch6_evt_in.fault_event
      |=> state_reg.flags[dcef_pkg::CH6_FAULT_BIT]
  ) else $error("A clear beat a simultaneous fault event.");

  zero_keeps_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    clr_wr && !wdata_in[dcef_pkg::CH6_HALF_BIT]
      && state_reg.flags[dcef_pkg::CH6_HALF_BIT]
      |=> state_reg.flags[dcef_pkg::CH6_HALF_BIT]
  ) else $error("A zero clear bit removed a flag.");

  status_wr_none_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    status_wr && !(|ch6_evt_in) && !(|ch7_evt_in)
      |=> state_reg.flags == $past(state_reg.flags)
  ) else $error("A status write changed the flags.");

  fall_needs_clear_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ($past(state_reg.flags) & ~state_reg.flags
      & ~($past(wdata_in) & {32{$past(clr_wr)}})) == '0
  ) else $error("A flag fell without a matching clear bit.");

  clear_removes_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    clr_wr && !(|ch6_evt_in) && !(|ch7_evt_in)
      |=> (state_reg.flags & $past(wdata_in)) == '0
  ) else $error("A flag survived a one in the clear register.");

  zero_bits_keep_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    clr_wr
      |=> ($past(state_reg.flags) & ~$past(wdata_in) & ~state_reg.flags) == '0
  ) else $error("A clear write removed a flag whose clear bit was zero.");

  // ----------------------------------------------------------------
  // Bus and interrupt checks
  // ----------------------------------------------------------------

  read_timing_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (addr_in == dcef_pkg::STATUS_OFS) && !clr_wr
      |=> rdata_out == $past(state_reg.flags) ##1 ($past(rd_in) || rdata_out == '0)
  ) else $error("Status read data wrong or held too long.");

  irq_level_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (addr_in == dcef_pkg::PENDING_OFS)
      |=> (rdata_out != '0) == $past(irq_out)
  ) else $error("Interrupt level disagrees with the pending register.");

  status_read_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (addr_in == dcef_pkg::STATUS_OFS)
      |=> rdata_out[dcef_pkg::CH7_HALF_BIT:dcef_pkg::CH6_ANY_BIT] == $past(flags_out)
        && (rdata_out & ~dcef_pkg::FLAG_MASK) == '0
  ) else $error("Status read disagrees with the flag outputs.");

  clear_rd_zero_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (addr_in == dcef_pkg::CLEAR_OFS)
      |=> rdata_out == '0
  ) else $error("The clear register did not read as zero.");

  mask_write_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    wr_in && (addr_in == dcef_pkg::MASK_OFS)
      |=> state_reg.mask == ($past(wdata_in) & dcef_pkg::FLAG_MASK)
  ) else $error("Mask write did not land.");

  mask_read_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (addr_in == dcef_pkg::MASK_OFS)
      |=> rdata_out == $past(state_reg.mask)
  ) else $error("Mask read data wrong.");

  pending_read_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && (addr_in == dcef_pkg::PENDING_OFS)
      |=> rdata_out == ($past(state_reg.flags) & $past(state_reg.mask))
  ) else $error("Pending read data wrong.");

  idle_rdata_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !rd_in |=> rdata_out == '0
  ) else $error("Read data stood without a read strobe.");

  rdata_field_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (rdata_out & ~dcef_pkg::FLAG_MASK) == '0
  ) else $error("Read data outside the flag field.");

  field_clean_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (state_reg.flags & ~dcef_pkg::FLAG_MASK) == '0
  ) else $error("A flag was set outside the flag field.");

  irq_rise_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(irq_out) |-> $past((|ch6_evt_in) || (|ch7_evt_in)
      || (wr_in && (addr_in == dcef_pkg::MASK_OFS)))
  ) else $error("Interrupt rose with no event and no mask write.");

  irq_fall_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $fell(irq_out) |-> $past(wr_in && ((addr_in == dcef_pkg::CLEAR_OFS)
      || (addr_in == dcef_pkg::MASK_OFS)))
  ) else $error("Interrupt fell with no clear and no mask write.");

endmodule

/* tb/tb_dcef_flags.sv */
// Self-checking testbench for the channel 6 and 7 event flag block.
module tb_dcef_flags;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  dcef_pkg::dcef_evt_t ev6 = '0;
  dcef_pkg::dcef_evt_t ev7 = '0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic [6:0] flags;
  logic [31:0] got;
  logic [31:0] exp_w;
  int error_cnt = 0;
  int cmp_count = 0;

  dcef_flags i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ch6_evt_in(ev6),
    .ch7_evt_in(ev7), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .irq_out(irq), .flags_out(flags));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string name, input logic [31:0] ev, input logic [31:0] sv);
    cmp_count++;
    if (sv !== ev) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, ev, sv);
    end
  endtask

  task automatic chk_bit(input string name, input logic ev, input logic sv);
    cmp_count++;
    if (sv !== ev) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", name, ev, sv);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Events are one-cycle pulses; a held level would set the flag again every cycle.
  task automatic pulse(input int ch, input int e);
    @(posedge clk_in);
    if (ch == 0) begin
      ev6 <= dcef_pkg::dcef_evt_t'(3'h1 << e);
    end else begin
      ev7 <= dcef_pkg::dcef_evt_t'(3'h1 << e);
    end
    @(posedge clk_in);
    ev6 <= '0;
    ev7 <= '0;
    #1;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int base;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    chk_word("flags reset", 32'h0000_0000, {25'h0, flags});
    chk_bit("irq reset", 1'b0, irq);
    bus_rd(dcef_pkg::STATUS_OFS, got);
    chk_word("status reset", dcef_pkg::FLAGS_RST, got);
    bus_rd(dcef_pkg::MASK_OFS, got);
    chk_word("mask reset", dcef_pkg::MASK_RST, got);
    // Channel 7 has no fault bit of its own, so bit 31 is masked off the expectation.
    for (int ch = 0; ch < 2; ch++) begin
      for (int e = 0; e < 3; e++) begin
        base = dcef_pkg::FIRST_CH_BIT + dcef_pkg::CH_STRIDE * ch;
        exp_w = ((32'h1 << base) | (32'h1 << (base + 1 + e))) & dcef_pkg::FLAG_MASK;
        pulse(ch, e);
        chk_word("flags_out", exp_w, {1'b0, flags, 24'h0});
        bus_rd(dcef_pkg::STATUS_OFS, got);
        chk_word("status set", exp_w, got);
        @(posedge clk_in);
        #1;
        chk_word("rdata idle", 32'h0000_0000, rdata);
        bus_wr(dcef_pkg::CLEAR_OFS, exp_w);
        bus_rd(dcef_pkg::STATUS_OFS, got);
        chk_word("status clr", 32'h0000_0000, got);
      end
    end
    pulse(0, 0);
    pulse(0, 1);
    bus_wr(dcef_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    chk_word("status wr", 32'h0700_0000, {1'b0, flags, 24'h0});
    bus_wr(dcef_pkg::CLEAR_OFS, 32'h0000_0000);
    chk_word("clear zero", 32'h0700_0000, {1'b0, flags, 24'h0});
    bus_wr(dcef_pkg::CLEAR_OFS, 32'h0200_0000);
    chk_word("clear one", 32'h0500_0000, {1'b0, flags, 24'h0});
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= dcef_pkg::CLEAR_OFS;
    wdata <= 32'h0C00_0000;
    ev6 <= dcef_pkg::dcef_evt_t'(3'h6);
    @(posedge clk_in);
    wr <= 1'b0;
    ev6 <= '0;
    #1;
    chk_word("set wins", 32'h0D00_0000, {1'b0, flags, 24'h0});
    bus_rd(dcef_pkg::CLEAR_OFS, got);
    chk_word("clear rd", 32'h0000_0000, got);
    bus_rd(8'h10, got);
    chk_word("unmapped rd", dcef_pkg::UNMAPPED_RD, got);
    bus_wr(dcef_pkg::MASK_OFS, 32'hFFFF_FFFF);
    chk_bit("irq on", 1'b1, irq);
    bus_rd(dcef_pkg::MASK_OFS, got);
    chk_word("mask rd", 32'h7F00_0000, got);
    bus_wr(dcef_pkg::MASK_OFS, 32'h4000_0000);
    chk_bit("irq masked", 1'b0, irq);
    pulse(1, 1);
    chk_bit("irq ch7", 1'b1, irq);
    bus_rd(dcef_pkg::PENDING_OFS, got);
    chk_word("pending", 32'h4000_0000, got);
    bus_wr(dcef_pkg::CLEAR_OFS, 32'h7F00_0000);
    chk_bit("irq clr", 1'b0, irq);
    chk_word("all clr", 32'h0000_0000, {1'b0, flags, 24'h0});
    print_verdict();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    print_verdict();
  end
endmodule
